// [rtl/phy_diag_defines.svh]
// Timing counts, widths and reset values of the maintenance block.
`ifndef PHY_DIAG_DEFINES_SVH
`define PHY_DIAG_DEFINES_SVH

`define CLK_PERIOD_NS 40
`define CHAIN_LEN 19
`define DIST_W 9
`define DIST_MAX 9'h1FF
`define DIST_RST 9'h000
`define CNT_W 16
`define BUSY_MAX_CYC 11'h44C
`define QUIET_TIME_NS 20000
`define QUIET_CYC ((`QUIET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TDR_PULSE_NS 80
`define TDR_PULSE_CYC ((`TDR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LP_INTERVAL_MS 16
`define LP_LONG_MS 64
`define LP_INTERVAL_CYC ((`LP_INTERVAL_MS * 1000000) / `CLK_PERIOD_NS)
`define LP_LONG_CYC ((`LP_LONG_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// [rtl/diag_pkg.sv]
// Types shared by the maintenance block.
package diag_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_QUIET = 3'h1,
		ST_PULSE = 3'h3,
		ST_LISTEN = 3'h2,
		ST_DONE = 3'h6
	} diag_state_type;

	typedef enum logic [1:0] {
		RES_NORMAL = 2'h0,
		RES_OPEN = 2'h1,
		RES_SHORT = 2'h2,
		RES_INVALID = 2'h3
	} result_type;
endpackage

// [rtl/chain_if.sv]
// Interface between the pin gathering logic and the nested gate chain.
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
interface chain_if;
	logic [`CHAIN_LEN-1:0] pins;
	logic chain_end;
	modport gate (input pins, output chain_end);
	modport drive (output pins, input chain_end);
endinterface

// [rtl/nand_chain.sv]
// Nested gate chain used for the board connection test.
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
module nand_chain (
	chain_if.gate ch
);
	logic [`CHAIN_LEN-1:0] stage;

	// ****************************************
	// Chain stages
	// ****************************************
	assign stage[0] = ~ch.pins[0]; // [RL8]
	genvar i;
	generate
		for (i = 1; i < `CHAIN_LEN; i++) begin : g_stage
			assign stage[i] = ~(ch.pins[i] & stage[i-1]); // [RL8]
		end
	endgenerate
	assign ch.chain_end = ~stage[`CHAIN_LEN-1];
endmodule

// [rtl/pulse_timer.sv]
// Divider that paces link pulses in the low-power no-link state.
`timescale 1ns/1ps
module pulse_timer #(
	parameter int unsigned INTERVAL_CYC = 400000,
	parameter int unsigned LONG_CYC = 1600000
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic long_sel,
	output logic tick
);
	localparam int CW = $clog2(LONG_CYC + 1);
	logic [CW-1:0] cnt;
	logic [CW-1:0] last;

	assign last = long_sel ? CW'(LONG_CYC - 1) : CW'(INTERVAL_CYC - 1);

	// ****************************************
	// Interval counter
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt >= last) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + CW'(1);
			tick <= 1'b0;
		end
	end
endmodule

// [rtl/phy_diag_and_power_modes.sv]
// Cable reflection test, board chain test and power modes of the transceiver.
// Contract
// RL1: Start bit launches test, clears when done.
// RL2: Host disables auto crossover, then polls start.
// RL3: Result codes normal, open, short, invalid.
// RL4: Unsilenced partner skips measurement, reports invalid.
// RL5: Fault distance is nine-bit unsigned count.
// RL6: Test pulse uses manually selected pair.
// RL7: Chain test entered by strap or software.
// RL8: Each pin feeds one gate; config pin outputs.
// RL9: Fixed chain order from management data to collision.
// RL10: Tester pulls inputs low in chain order.
// RL11: Each pulled input toggles the chain output.
// RL12: Power saving needs autonegotiation and no link.
// RL13: Power saving keeps transmitter, detector, PLL only.
// RL14: Energy detect down enabled by cleared bit.
// RL15: Optional PLL stop during energy detect down.
// RL16: Periodic link pulses sent while sleeping.
// RL17: Both low-power modes start disabled.
// RL18: Power-down leaves only management alive.
// RL19: Slow oscillator replaces reference clock input.
// RL20: Host exits slow oscillator in fixed order.
// RL21: Manual bit picks straight or crossed pairs.
// RL22: Results hold until next test completes.
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
module phy_diag_and_power_modes #(
	parameter int unsigned LP_INTERVAL_CYC = `LP_INTERVAL_CYC,
	parameter int unsigned LP_LONG_CYC = `LP_LONG_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cable_test_start,
	input wire logic auto_xover_off,
	input wire logic mdix_select,
	input wire logic auto_xover_crossed,
	input wire logic line_quiet,
	input wire logic echo_seen,
	input wire logic echo_short,
	input wire logic power_save_en,
	input wire logic energy_detect_powerdown_n,
	input wire logic pll_auto_off,
	input wire logic power_down,
	input wire logic slow_osc_sel,
	input wire logic soft_reset,
	input wire logic long_pulse_interval,
	input wire logic autoneg_en,
	input wire logic link_up,
	input wire logic nand_strap,
	input wire logic nand_sw_en,
	input wire logic mdio_in,
	input wire logic mdc_in,
	input wire logic [3:0] rxd_in,
	input wire logic rx_dv_in,
	input wire logic rx_clk_in,
	input wire logic rx_er_in,
	input wire logic irq_out_pin_in,
	input wire logic tx_clk_in,
	input wire logic tx_en_in,
	input wire logic [3:0] txd_in,
	input wire logic status_lamp_a_in,
	input wire logic status_lamp_b_in,
	input wire logic col_in,
	output logic test_busy,
	output diag_pkg::result_type test_result,
	output logic [`DIST_W-1:0] fault_distance,
	output logic partner_hush,
	output logic tdr_pulse,
	output logic tdr_pair_crossed,
	output logic mdi_crossed,
	output logic nand_mode,
	output logic strap_cfg_one_out,
	output logic strap_cfg_one_oe_n,
	output logic rx_blocks_on,
	output logic tx_on,
	output logic energy_det_on,
	output logic pll_on,
	output logic clk_slow_sel,
	output logic link_pulse
);
	import diag_pkg::*;

	diag_state_type state;
	diag_state_type next_state;
	logic [`CNT_W-1:0] cnt;
	logic [`DIST_W-1:0] dist_cnt;
	logic abort;
	logic quiet_timeout;
	logic pulse_end;
	logic listen_end;
	logic strap_latched;
	logic no_link_idle;
	logic ps_eff;
	logic energy_detect_powerdown_eff;
	logic lp_tick;
	logic [10:0] busy_len;
	chain_if ch ();

	// ****************************************
	// Cable reflection test sequencer
	// ****************************************
	assign abort = soft_reset | power_down;
	assign quiet_timeout = !line_quiet && (cnt == `CNT_W'(`QUIET_CYC - 1));
	assign pulse_end = (cnt == `CNT_W'(`TDR_PULSE_CYC - 1));
	assign listen_end = echo_seen || (dist_cnt == `DIST_MAX);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cable_test_start) begin
					next_state = ST_QUIET; // [RL1]
				end
			end
			ST_QUIET: begin
				if (line_quiet) begin
					next_state = ST_PULSE;
				end else if (quiet_timeout) begin
					next_state = ST_DONE; // [RL4]
				end
			end
			ST_PULSE: begin
				if (pulse_end) begin
					next_state = ST_LISTEN;
				end
			end
			ST_LISTEN: begin
				if (listen_end) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (abort) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || next_state != state) begin
			cnt <= '0;
		end else if (state == ST_QUIET || state == ST_PULSE) begin
			cnt <= cnt + `CNT_W'(1);
		end
	end

	// The echo delay counts one step per clock; the host scales it to metres.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state != ST_LISTEN) begin
			dist_cnt <= `DIST_RST;
		end else if (!listen_end) begin
			dist_cnt <= dist_cnt + `DIST_W'(1); // [RL5]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			test_busy <= 1'b0;
			partner_hush <= 1'b0;
			tdr_pulse <= 1'b0;
		end else begin
			test_busy <= next_state != ST_IDLE && next_state != ST_DONE; // [RL1]
			partner_hush <= next_state == ST_QUIET || next_state == ST_PULSE || next_state == ST_LISTEN;
			tdr_pulse <= next_state == ST_PULSE;
		end
	end

	// Results change only when a test completes.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			test_result <= RES_NORMAL;
			fault_distance <= `DIST_RST;
		end else if (!abort && state == ST_QUIET && !line_quiet && quiet_timeout) begin
			test_result <= RES_INVALID; // [RL4] [RL22]
			fault_distance <= `DIST_RST;
		end else if (!abort && state == ST_LISTEN && echo_seen) begin
			test_result <= echo_short ? RES_SHORT : RES_OPEN; // [RL3] [RL22]
			fault_distance <= dist_cnt; // [RL5]
		end else if (!abort && state == ST_LISTEN && listen_end) begin
			test_result <= RES_NORMAL; // [RL3]
			fault_distance <= `DIST_RST;
		end
	end

	// ****************************************
	// Pair selection
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tdr_pair_crossed <= 1'b0;
			mdi_crossed <= 1'b0;
		end else begin
			if (state == ST_IDLE && next_state == ST_QUIET) begin
				tdr_pair_crossed <= mdix_select; // [RL6]
			end
			mdi_crossed <= auto_xover_off ? mdix_select : auto_xover_crossed; // [RL21]
		end
	end

	// ****************************************
	// Board chain test
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			strap_latched <= nand_strap; // [RL7]
		end
	end

	assign ch.pins = {col_in, status_lamp_b_in, status_lamp_a_in, txd_in[3], txd_in[2], txd_in[1], txd_in[0],
		tx_en_in, tx_clk_in, irq_out_pin_in, rx_er_in, rx_clk_in, rx_dv_in,
		rxd_in[0], rxd_in[1], rxd_in[2], rxd_in[3], mdc_in, mdio_in}; // [RL9]

	nand_chain u_chain (
		.ch(ch.gate)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nand_mode <= 1'b0;
			strap_cfg_one_out <= 1'b0;
			strap_cfg_one_oe_n <= 1'b1;
		end else begin
			nand_mode <= strap_latched | nand_sw_en; // [RL7]
			strap_cfg_one_out <= ch.chain_end; // [RL8] [RL11]
			strap_cfg_one_oe_n <= !(strap_latched | nand_sw_en);
		end
	end

	// ****************************************
	// Power modes
	// ****************************************
	assign no_link_idle = autoneg_en && !link_up;
	assign ps_eff = power_save_en && no_link_idle && !power_down; // [RL12]
	assign energy_detect_powerdown_eff = !energy_detect_powerdown_n && no_link_idle && !power_down; // [RL14]

	// Reset leaves every block running and both low-power modes off.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_blocks_on <= 1'b1; // [RL17]
			tx_on <= 1'b1;
			energy_det_on <= 1'b1;
			pll_on <= 1'b1;
			clk_slow_sel <= 1'b0;
		end else begin
			rx_blocks_on <= !(power_down || ps_eff || energy_detect_powerdown_eff); // [RL13] [RL18]
			tx_on <= !power_down; // [RL18]
			energy_det_on <= !power_down;
			pll_on <= !(power_down || (energy_detect_powerdown_eff && pll_auto_off)); // [RL15]
			clk_slow_sel <= slow_osc_sel; // [RL19]
		end
	end

	pulse_timer #(
		.INTERVAL_CYC(LP_INTERVAL_CYC),
		.LONG_CYC(LP_LONG_CYC)
	) u_timer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(ps_eff || energy_detect_powerdown_eff),
		.long_sel(long_pulse_interval),
		.tick(lp_tick)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			link_pulse <= 1'b0;
		end else begin
			link_pulse <= lp_tick && (ps_eff || energy_detect_powerdown_eff); // [RL16]
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// ****************************************
	// Test length watch
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !test_busy) begin
			busy_len <= '0;
		end else if (busy_len != `BUSY_MAX_CYC) begin
			busy_len <= busy_len + 11'h001;
		end
	end

	sequence test_launch;
		state == ST_IDLE && cable_test_start && !abort;
	endsequence

	sequence one_pin_drop;
		nand_mode && $past(nand_mode) && $onehot($past(ch.pins) & ~ch.pins)
			&& ((((($past(ch.pins) & ~ch.pins) - `CHAIN_LEN'(1))) & ch.pins) == '0)
			&& (($past(ch.pins) & ~ch.pins) == ($past(ch.pins) ^ ch.pins));
	endsequence

	a_start_busy: assert property (test_launch |=> test_busy && partner_hush) // [RL1]
		else $error("Test start did not raise busy.");
	a_busy_ends: assert property (test_busy |-> busy_len < `BUSY_MAX_CYC) // [RL1]
		else $error("Cable test did not finish in time.");
	a_abort_idle: assert property (abort |=> !test_busy && !partner_hush && !tdr_pulse) // [RL1]
		else $error("Abort did not stop the cable test.");
	a_invalid_code: assert property (test_launch ##1 (!line_quiet && !abort)[*8]
		|-> ##[1:600] (test_result == RES_INVALID || line_quiet || abort)) // [RL4]
		else $error("Noisy line did not give the invalid code.");
	a_echo_result: assert property (state == ST_LISTEN && echo_seen && !abort
		|=> test_result == ($past(echo_short) ? RES_SHORT : RES_OPEN) && fault_distance == $past(dist_cnt)) // [RL3]
		else $error("Echo result or distance wrong.");
	a_result_hold: assert property (state == ST_IDLE |=> $stable(test_result) && $stable(fault_distance)) // [RL22]
		else $error("Result changed without a test.");
	a_pair_pick: assert property (test_launch |=> tdr_pair_crossed == $past(mdix_select)) // [RL6]
		else $error("Test pair does not follow manual selection.");
	a_mdi_map: assert property (auto_xover_off |=> mdi_crossed == $past(mdix_select)) // [RL21]
		else $error("Manual pair mapping not applied.");
	a_pulse_gate: assert property (link_pulse |-> $past(ps_eff || energy_detect_powerdown_eff)) // [RL16]
		else $error("Link pulse outside the low-power state.");
	a_chain_toggle: assert property (one_pin_drop |=> strap_cfg_one_out != $past(strap_cfg_one_out)) // [RL11]
		else $error("Chain output did not toggle.");
	a_chain_drive: assert property (nand_sw_en |=> nand_mode && !strap_cfg_one_oe_n) // [RL7]
		else $error("Software did not enter chain mode.");
	a_save_blocks: assert property (ps_eff && !energy_detect_powerdown_eff |=> !rx_blocks_on && tx_on && pll_on && energy_det_on) // [RL13]
		else $error("Power saving left wrong blocks on.");
	a_pll_stop: assert property (energy_detect_powerdown_eff && pll_auto_off |=> !pll_on && tx_on && energy_det_on) // [RL15]
		else $error("PLL not stopped in energy detect down.");
	a_power_down: assert property (power_down |=> !rx_blocks_on && !tx_on && !pll_on && !test_busy) // [RL18]
		else $error("Power-down left functions running.");
	a_slow_clock: assert property (slow_osc_sel |=> clk_slow_sel) // [RL19]
		else $error("Slow oscillator not selected.");
endmodule

// [verif/line_model.sv]
// Model of the cable and link partner seen by the reflection test.
`timescale 1ns/1ps
module line_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic partner_hush,
	input wire logic tdr_pulse,
	input wire logic [9:0] quiet_after,
	input wire logic [9:0] echo_after,
	input wire logic want_short,
	output logic line_quiet,
	output logic echo_seen,
	output logic echo_short
);
	logic [9:0] cq;
	logic [9:0] ce;
	logic armed;
	logic flip;
	logic listening;
	assign listening = armed & ~tdr_pulse;
	// The partner falls silent only after the hush has lasted a while.
	assign line_quiet = partner_hush & (cq >= quiet_after);
	// A reflection returns a set number of listen cycles after the pulse.
	assign echo_seen = listening & (ce == echo_after);
	// The kind line toggles when no reflection qualifies it.
	assign echo_short = echo_seen ? want_short : flip;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flip <= 1'b0;
		end else begin
			flip <= ~flip;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst | ~partner_hush) begin
			cq <= 10'h000;
			ce <= 10'h000;
			armed <= 1'b0;
		end else begin
			cq <= cq + 10'h001;
			if (tdr_pulse) begin
				armed <= 1'b1;
			end
			if (listening) begin
				ce <= ce + 10'h001;
			end
		end
	end
endmodule

// [verif/phy_diag_and_power_modes_tb_top.sv]
// Self-checking bench of the maintenance block.
`timescale 1ns/1ps
`include "phy_diag_defines.svh"
module phy_diag_and_power_modes_tb_top;
	import diag_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, cable_test_start = 1'b0, auto_xover_off = 1'b0, mdix_select = 1'b0;
	logic auto_xover_crossed = 1'b0, power_save_en = 1'b0, energy_detect_powerdown_n = 1'b1, pll_auto_off = 1'b0;
	logic power_down = 1'b0, slow_osc_sel = 1'b0, soft_reset = 1'b0, long_pulse_interval = 1'b0, autoneg_en = 1'b0;
	logic link_up = 1'b0, nand_strap = 1'b0, nand_sw_en = 1'b0, want_short = 1'b0;
	logic [9:0] quiet_after = 10'h003, echo_after = 10'h3FF;
	logic [18:0] cv = 19'h7FFFF;
	wire mdio_in = cv[0], mdc_in = cv[1], rx_dv_in = cv[6], rx_clk_in = cv[7], rx_er_in = cv[8];
	wire irq_out_pin_in = cv[9], tx_clk_in = cv[10], tx_en_in = cv[11];
	wire status_lamp_a_in = cv[16], status_lamp_b_in = cv[17], col_in = cv[18];
	wire [3:0] rxd_in = {cv[2], cv[3], cv[4], cv[5]};
	wire [3:0] txd_in = {cv[15], cv[14], cv[13], cv[12]};
	logic test_busy, partner_hush, tdr_pulse, tdr_pair_crossed, mdi_crossed, nand_mode, strap_cfg_one_out;
	logic strap_cfg_one_oe_n, rx_blocks_on, tx_on, energy_det_on, pll_on, clk_slow_sel, link_pulse;
	logic line_quiet, echo_seen, echo_short;
	result_type test_result;
	logic [8:0] fault_distance;
	int n_mismatch = 0;
	int comparisons = 0;
	phy_diag_and_power_modes #(.LP_INTERVAL_CYC(20), .LP_LONG_CYC(40)) u_phy_diag_and_power_modes (.*);
	line_model u_line_model (.*);
	initial forever #20 clk_sys = ~clk_sys;
	// ****************
	// Shared tasks.
	// ****************
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic give_up();
		n_mismatch++;
		$display("[ERR] %0t wait ran out", $time);
		print_verdict();
	endtask
	// ****************
	// Scenarios.
	// ****************
	task automatic t_reset(input logic sv);
		sys_rst = 1'b1;
		nand_strap = sv;
		cyc(3);
		sys_rst = 1'b0;
		nand_strap = 1'b0;
		cyc(1);
		check(nand_mode, sv);
		check({test_busy, test_result, fault_distance}, 12'h000);
		check({rx_blocks_on, tx_on, energy_det_on, pll_on, clk_slow_sel}, 12'h01E);
		$display("reset test done");
	endtask
	task automatic t_cable(input logic [9:0] q, input logic [9:0] e, input logic sh, input logic mx,
			input logic [1:0] er, input logic [8:0] ed);
		logic [10:0] prev;
		int i;
		int np;
		prev = {test_result, fault_distance};
		auto_xover_off = 1'b0;
		auto_xover_crossed = !mx;
		mdix_select = mx;
		cyc(1);
		check(mdi_crossed, !mx);
		auto_xover_off = 1'b1;
		quiet_after = q;
		echo_after = e;
		want_short = sh;
		cyc(1);
		cable_test_start = 1'b1;
		cyc(1);
		cable_test_start = 1'b0;
		check({test_busy, partner_hush}, 12'h003);
		check({test_result, fault_distance}, prev);
		np = 0;
		for (i = 0; i < 2000 && test_busy !== 1'b0; i++) begin
			if (tdr_pulse === 1'b1) np++;
			cyc(1);
		end
		if (test_busy !== 1'b0) give_up();
		check(12'(np), (er == 2'b11) ? 12'h000 : 12'(`TDR_PULSE_CYC));
		check({partner_hush, tdr_pulse}, 12'h000);
		check(test_result, er);
		check(fault_distance, ed);
		check({tdr_pair_crossed, mdi_crossed}, {mx, mx});
		$display("cable test done");
	endtask
	task automatic t_abort(input logic pd);
		logic [10:0] prev;
		prev = {test_result, fault_distance};
		quiet_after = 10'h3FF;
		cyc(1);
		cable_test_start = 1'b1;
		cyc(1);
		cable_test_start = 1'b0;
		cyc(4);
		{power_down, soft_reset} = {pd, !pd};
		cyc(1);
		{power_down, soft_reset} = 2'b00;
		check({test_busy, partner_hush}, 12'h000);
		check({test_result, fault_distance}, prev);
		cyc(1);
		$display("abort test done");
	endtask
	task automatic t_chain();
		int i;
		cv = 19'h7FFFF;
		nand_sw_en = 1'b1;
		cyc(2);
		check({nand_mode, strap_cfg_one_oe_n, strap_cfg_one_out}, 12'h005);
		for (i = 0; i < 19; i++) begin
			cv[i] = 1'b0;
			cyc(1);
			check(strap_cfg_one_out, i[0]);
		end
		nand_sw_en = 1'b0;
		cv = 19'h7FFFF;
		cyc(2);
		check({nand_mode, strap_cfg_one_oe_n}, 12'h001);
		$display("chain test done");
	endtask
	task automatic pulse_gap(input logic lg, input logic [11:0] exp);
		int g;
		autoneg_en = 1'b0;
		long_pulse_interval = lg;
		cyc(2);
		autoneg_en = 1'b1;
		for (g = 0; g < 200 && link_pulse !== 1'b1; g++) cyc(1);
		if (link_pulse !== 1'b1) give_up();
		cyc(1);
		for (g = 1; g < 200 && link_pulse !== 1'b1; g++) cyc(1);
		if (link_pulse !== 1'b1) give_up();
		check(12'(g), exp);
	endtask
	task automatic t_power();
		int i;
		logic ps;
		logic ed;
		for (i = 0; i < 64; i++) begin
			{power_save_en, energy_detect_powerdown_n, pll_auto_off, power_down, autoneg_en, link_up} = i[5:0];
			cyc(1);
			ps = power_save_en & autoneg_en & ~link_up & ~power_down;
			ed = ~energy_detect_powerdown_n & autoneg_en & ~link_up & ~power_down;
			check(rx_blocks_on, !(power_down | ps | ed));
			check({tx_on, energy_det_on}, {~power_down, ~power_down});
			check(pll_on, !(power_down | (ed & pll_auto_off)));
		end
		{power_save_en, energy_detect_powerdown_n, pll_auto_off, power_down, autoneg_en, link_up} = 6'h32;
		pulse_gap(1'b0, 12'd20);
		{power_save_en, energy_detect_powerdown_n} = 2'b00;
		pulse_gap(1'b1, 12'd40);
		link_up = 1'b1;
		for (i = 0; i < 60; i++) begin
			cyc(1);
			check(link_pulse, 1'b0);
		end
		power_down = 1'b1;
		slow_osc_sel = 1'b1;
		cyc(1);
		check({clk_slow_sel, pll_on, tx_on}, 12'h004);
		slow_osc_sel = 1'b0;
		cyc(1);
		power_down = 1'b0;
		cyc(1);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		check({clk_slow_sel, pll_on, tx_on}, 12'h003);
		$display("power test done");
	endtask
	initial begin
		t_reset(1'b0);
		t_cable(10'h003, 10'h005, 1'b0, 1'b0, 2'b01, 9'h005);
		t_cable(10'h003, 10'h000, 1'b1, 1'b1, 2'b10, 9'h000);
		t_cable(10'h003, 10'h12C, 1'b1, 1'b0, 2'b10, 9'h12C);
		t_cable(10'h003, 10'h3FF, 1'b0, 1'b1, 2'b00, 9'h000);
		t_cable(10'h3FF, 10'h3FF, 1'b0, 1'b0, 2'b11, 9'h000);
		t_abort(1'b0);
		t_abort(1'b1);
		t_chain();
		t_reset(1'b1);
		t_reset(1'b0);
		t_power();
		print_verdict();
	end
endmodule
